// *** pob_pkg.sv ***
// Package with register map, field positions, reset values and timing counts
`default_nettype none
package pob_pkg;
  localparam int          NUM_CH          = 4;
  localparam int          ADDR_W          = 8;
  // Register byte offsets
  localparam logic [7:0]  BRK_DEADTIME_OFS = 8'h00;
  localparam logic [7:0]  CTRL2_OFS        = 8'h04;
  localparam logic [7:0]  CC_ENABLE_OFS    = 8'h08;
  localparam logic [7:0]  TIMER_STATUS_OFS = 8'h0C;
  localparam logic [7:0]  IRQ_DMA_EN_OFS   = 8'h10;
  localparam logic [7:0]  EVENT_GEN_OFS    = 8'h14;
  // Break and dead-time register fields
  localparam int          DT_LSB          = 0;
  localparam int          LOCK_LSB        = 8;
  localparam int          IDLE_OSS_BIT    = 10;
  localparam int          RUN_OSS_BIT     = 11;
  localparam int          BRK_EN_BIT      = 12;
  localparam int          BRK_POL_BIT     = 13;
  localparam int          AUTO_OE_BIT     = 14;
  localparam int          MOE_BIT         = 15;
  // Enable register fields, four bits per channel
  localparam int          CC_STRIDE       = 4;
  localparam int          MAIN_EN_OFS     = 0;
  localparam int          MAIN_POL_OFS    = 1;
  localparam int          COMPL_EN_OFS    = 2;
  localparam int          COMPL_POL_OFS   = 3;
  // Status, enable and event fields
  localparam int          BRK_FLAG_BIT    = 0;
  localparam int          BRK_IRQ_EN_BIT  = 0;
  localparam int          BRK_DMA_EN_BIT  = 1;
  localparam int          SW_BRK_BIT      = 0;
  // Reset values
  localparam logic [15:0] BDTR_RST        = 16'h0000;
  localparam logic [7:0]  CTRL2_RST       = 8'h00;
  localparam logic [15:0] CCER_RST        = 16'h0000;
  // Extra dead-time after a break, caused by enable resynchronisation
  localparam int          BRK_DT_EXTRA    = 2;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage
`default_nettype wire

// *** pob_top.sv ***
// Output steering, dead-time and break logic of a complementary PWM channel group
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pob_top
  import pob_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic [NUM_CH-1:0] REF_WAVE,
  input  wire logic              UPDATE_EVENT,
  input  wire logic              BRK_IN,
  input  wire logic              CLOCK_FAIL_MONITOR,
  output logic      [NUM_CH-1:0] MAIN_OUT,
  output logic      [NUM_CH-1:0] MAIN_OUT_OE,
  output logic      [NUM_CH-1:0] COMPL_OUT,
  output logic      [NUM_CH-1:0] COMPL_OUT_OE,
  output logic                   BRK_IRQ,
  output logic                   BRK_DMA_REQ,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic      [1:0]        S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic      [31:0]       S_AXI_RDATA,
  output logic      [1:0]        S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  typedef struct packed {
    logic [7:0]             dt;
    logic [1:0]             lock;
    logic                   lock_done;
    logic                   idle_off_state_sel;
    logic                   run_off_state_sel;
    logic                   brk_enable;
    logic                   brk_polarity;
    logic                   bk_pend;
    logic                   bke_new;
    logic                   bkp_new;
    logic                   auto_out_en;
    logic                   master_out_en;
    logic [7:0]             ois;
    logic [15:0]            ccer;
    logic                   flag;
    logic                   irq_en;
    logic                   dma_en;
    logic                   sw_brk;
    logic                   brk_s1;
    logic                   brk_s2;
    logic                   cf_s1;
    logic                   cf_s2;
    logic                   moe_s1;
    logic                   moe_s2;
    logic [NUM_CH-1:0]      ref_prev;
    logic [NUM_CH-1:0][7:0] dt_cnt;
    logic [8:0]             idle_cnt;
    logic [NUM_CH-1:0]      main_lvl;
    logic [NUM_CH-1:0]      compl_lvl;
    logic [NUM_CH-1:0]      main_oe;
    logic [NUM_CH-1:0]      compl_oe;
    logic                   awh;
    logic                   wh;
    logic [ADDR_W-1:0]      awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } pob_state_t;

  pob_state_t state_reg;
  pob_state_t state_next;

  logic       brk_async;
  logic       brk_lvl;
  logic       brk_ev;
  logic       moe_eff;
  logic       do_wr;
  logic       ar_take;
  logic [8:0] idle_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Break detection
  // Raw pin path acts without the clock; synced path drives flags and enable
  assign brk_async = (state_reg.brk_enable & (BRK_IN == state_reg.brk_polarity)) | CLOCK_FAIL_MONITOR;
  assign brk_lvl   = (state_reg.brk_enable & (state_reg.brk_s2 == state_reg.brk_polarity)) | state_reg.cf_s2;
  assign brk_ev    = brk_lvl | state_reg.sw_brk;
  assign moe_eff   = state_reg.master_out_en & ~brk_async;
  assign idle_lim  = {1'b0, state_reg.dt} + 9'(BRK_DT_EXTRA);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  assign S_AXI_AWREADY = ~state_reg.awh;
  assign S_AXI_WREADY  = ~state_reg.wh;
  assign S_AXI_ARREADY = ~state_reg.rvalid;
  assign S_AXI_BVALID  = state_reg.bvalid;
  assign S_AXI_BRESP   = state_reg.bresp;
  assign S_AXI_RVALID  = state_reg.rvalid;
  assign S_AXI_RRESP   = state_reg.rresp;
  assign S_AXI_RDATA   = state_reg.rdata;
  assign do_wr         = state_reg.awh & state_reg.wh & ~state_reg.bvalid;
  assign ar_take       = S_AXI_ARVALID & ~state_reg.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [31:0] wd;
    logic        mact;
    logic        cact;
    logic        ce;
    logic        cne;
    logic        cp;
    logic        cnp;
    wd         = 32'h0000_0000;
    mact       = 1'b0;
    cact       = 1'b0;
    ce         = 1'b0;
    cne        = 1'b0;
    cp         = 1'b0;
    cnp        = 1'b0;
    state_next = state_reg;

    // Synchronisers
    state_next.brk_s1 = BRK_IN;
    state_next.brk_s2 = state_reg.brk_s1;
    state_next.cf_s1  = CLOCK_FAIL_MONITOR;
    state_next.cf_s2  = state_reg.cf_s1;
    state_next.moe_s1 = moe_eff;
    state_next.moe_s2 = state_reg.moe_s1;
    state_next.sw_brk = 1'b0;

    // Delayed break enable and polarity
    if (state_reg.bk_pend)
    begin
      state_next.brk_enable     = state_reg.bke_new;
      state_next.brk_polarity     = state_reg.bkp_new;
      state_next.bk_pend = 1'b0;
    end

    // Write channel
    if (S_AXI_AWVALID & ~state_reg.awh)
    begin
      state_next.awh    = 1'b1;
      state_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & ~state_reg.wh)
    begin
      state_next.wh    = 1'b1;
      state_next.wdata = S_AXI_WDATA;
      state_next.wstrb = S_AXI_WSTRB;
    end
    if (state_reg.bvalid & S_AXI_BREADY)
      state_next.bvalid = 1'b0;
    if (do_wr)
    begin
      state_next.awh    = 1'b0;
      state_next.wh     = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      for (int b = 0; b < 4; b++)
        wd[b*8 +: 8] = state_reg.wstrb[b] ? state_reg.wdata[b*8 +: 8] : 8'h00;
      unique case (state_reg.awaddr)
        BRK_DEADTIME_OFS:
        begin
          if (state_reg.wstrb[0] && state_reg.lock == 2'b00)
            state_next.dt = wd[DT_LSB +: 8];
          if (state_reg.wstrb[1])
          begin
            if (!state_reg.lock_done)
            begin
              state_next.lock      = wd[LOCK_LSB +: 2];
              state_next.lock_done = 1'b1;
            end
            if (state_reg.lock < 2'd2)
            begin
              state_next.idle_off_state_sel = wd[IDLE_OSS_BIT];
              state_next.run_off_state_sel = wd[RUN_OSS_BIT];
            end
            if (state_reg.lock == 2'b00)
            begin
              state_next.bke_new = wd[BRK_EN_BIT];
              state_next.bkp_new = wd[BRK_POL_BIT];
              state_next.bk_pend = 1'b1;
              state_next.auto_out_en     = wd[AUTO_OE_BIT];
            end
            if (!wd[MOE_BIT])
              state_next.master_out_en = 1'b0;
            else if (!brk_ev)
              state_next.master_out_en = 1'b1;
          end
        end
        CTRL2_OFS:
          if (state_reg.wstrb[0] && state_reg.lock == 2'b00)
            state_next.ois = wd[7:0];
        CC_ENABLE_OFS:
          for (int i = 0; i < NUM_CH; i++)
          begin
            state_next.ccer[i*CC_STRIDE+MAIN_EN_OFS]  = wd[i*CC_STRIDE+MAIN_EN_OFS];
            state_next.ccer[i*CC_STRIDE+COMPL_EN_OFS] = wd[i*CC_STRIDE+COMPL_EN_OFS];
            if (state_reg.lock < 2'd2)
            begin
              state_next.ccer[i*CC_STRIDE+MAIN_POL_OFS]  = wd[i*CC_STRIDE+MAIN_POL_OFS];
              state_next.ccer[i*CC_STRIDE+COMPL_POL_OFS] = wd[i*CC_STRIDE+COMPL_POL_OFS];
            end
          end
        TIMER_STATUS_OFS:
          if (state_reg.wstrb[0] && !wd[BRK_FLAG_BIT] && !brk_lvl)
            state_next.flag = 1'b0;
        IRQ_DMA_EN_OFS:
          if (state_reg.wstrb[0])
          begin
            state_next.irq_en = wd[BRK_IRQ_EN_BIT];
            state_next.dma_en = wd[BRK_DMA_EN_BIT];
          end
        EVENT_GEN_OFS:
          state_next.sw_brk = state_reg.wstrb[0] & wd[SW_BRK_BIT];
        default:
          state_next.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel
    if (state_reg.rvalid & S_AXI_RREADY)
      state_next.rvalid = 1'b0;
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      unique case (S_AXI_ARADDR)
        BRK_DEADTIME_OFS: state_next.rdata = {16'h0000, state_reg.moe_s2, state_reg.auto_out_en,
                                              state_reg.brk_polarity, state_reg.brk_enable, state_reg.run_off_state_sel,
                                              state_reg.idle_off_state_sel, state_reg.lock, state_reg.dt};
        CTRL2_OFS:        state_next.rdata = {24'h00_0000, state_reg.ois};
        CC_ENABLE_OFS:    state_next.rdata = {16'h0000, state_reg.ccer};
        TIMER_STATUS_OFS: state_next.rdata = {31'h0000_0000, state_reg.flag};
        IRQ_DMA_EN_OFS:   state_next.rdata = {30'h0000_0000, state_reg.dma_en, state_reg.irq_en};
        EVENT_GEN_OFS:    state_next.rdata = 32'h0000_0000;
        default:
        begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Break flag and master enable; break wins over any clear or set
    if (brk_ev)
    begin
      state_next.flag = 1'b1;
      state_next.master_out_en  = 1'b0;
    end
    else if (state_reg.auto_out_en && UPDATE_EVENT)
      state_next.master_out_en = 1'b1;

    // Idle dead-time counter after master enable falls
    if (state_reg.master_out_en)
      state_next.idle_cnt = 9'h000;
    else if (state_reg.idle_cnt < idle_lim)
      state_next.idle_cnt = state_reg.idle_cnt + 9'h001;

    // Per-channel dead-time and steering
    for (int i = 0; i < NUM_CH; i++)
    begin
      ce  = state_reg.ccer[i*CC_STRIDE+MAIN_EN_OFS];
      cne = state_reg.ccer[i*CC_STRIDE+COMPL_EN_OFS];
      cp  = state_reg.ccer[i*CC_STRIDE+MAIN_POL_OFS];
      cnp = state_reg.ccer[i*CC_STRIDE+COMPL_POL_OFS];
      state_next.ref_prev[i] = REF_WAVE[i];
      if (REF_WAVE[i] != state_reg.ref_prev[i])
        state_next.dt_cnt[i] = state_reg.dt;
      else if (state_reg.dt_cnt[i] != 8'h00)
        state_next.dt_cnt[i] = state_reg.dt_cnt[i] - 8'h01;
      if (state_reg.master_out_en && !brk_ev)
      begin
        unique case ({ce, cne})
          2'b11:
          begin
            mact = REF_WAVE[i] & (state_next.dt_cnt[i] == 8'h00);
            cact = ~REF_WAVE[i] & (state_next.dt_cnt[i] == 8'h00);
          end
          2'b10:
          begin
            mact = REF_WAVE[i];
            cact = 1'b0;
          end
          2'b01:
          begin
            mact = 1'b0;
            cact = REF_WAVE[i];
          end
          2'b00:
          begin
            mact = 1'b0;
            cact = 1'b0;
          end
        endcase
        state_next.main_lvl[i]  = mact ^ cp;
        state_next.compl_lvl[i] = cact ^ cnp;
        state_next.main_oe[i]   = ce | state_reg.run_off_state_sel;
        state_next.compl_oe[i]  = cne | state_reg.run_off_state_sel;
      end
      else
      begin
        if (state_next.idle_cnt >= idle_lim)
        begin
          state_next.main_lvl[i]  = state_reg.ois[2*i];
          state_next.compl_lvl[i] = state_reg.ois[2*i+1];
          if ((state_reg.ois[2*i] != cp) && (state_reg.ois[2*i+1] != cnp))
            state_next.compl_lvl[i] = cnp;
        end
        else
        begin
          state_next.main_lvl[i]  = cp;
          state_next.compl_lvl[i] = cnp;
        end
        state_next.main_oe[i]  = state_reg.idle_off_state_sel & (ce | cne);
        state_next.compl_oe[i] = state_reg.idle_off_state_sel & (ce | cne);
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg          <= '0;
      state_reg.dt       <= BDTR_RST[7:0];
      state_reg.ois      <= CTRL2_RST;
      state_reg.ccer     <= CCER_RST;
      state_reg.idle_cnt <= 9'h1FF;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage with asynchronous break override
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_out
      logic cp_g;
      logic cnp_g;
      logic en_any;
      assign cp_g            = state_reg.ccer[g*CC_STRIDE+MAIN_POL_OFS];
      assign cnp_g           = state_reg.ccer[g*CC_STRIDE+COMPL_POL_OFS];
      assign en_any          = state_reg.ccer[g*CC_STRIDE+MAIN_EN_OFS]
                             | state_reg.ccer[g*CC_STRIDE+COMPL_EN_OFS];
      assign MAIN_OUT[g]     = (brk_async & state_reg.master_out_en) ? cp_g : state_reg.main_lvl[g];
      assign COMPL_OUT[g]    = (brk_async & state_reg.master_out_en) ? cnp_g : state_reg.compl_lvl[g];
      assign MAIN_OUT_OE[g]  = (brk_async & state_reg.master_out_en) ? (state_reg.idle_off_state_sel & en_any)
                                                           : state_reg.main_oe[g];
      assign COMPL_OUT_OE[g] = (brk_async & state_reg.master_out_en) ? (state_reg.idle_off_state_sel & en_any)
                                                           : state_reg.compl_oe[g];
    end
  endgenerate

  assign BRK_IRQ     = state_reg.flag & state_reg.irq_en;
  assign BRK_DMA_REQ = state_reg.flag & state_reg.dma_en;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  logic [NUM_CH-1:0] main_act;
  logic [NUM_CH-1:0] compl_act;
  logic              bdtr_wr;
  generate
    for (genvar a = 0; a < NUM_CH; a++)
    begin : g_act
      assign main_act[a]  = MAIN_OUT_OE[a] & (MAIN_OUT[a] != state_reg.ccer[a*CC_STRIDE+1]);
      assign compl_act[a] = COMPL_OUT_OE[a] & (COMPL_OUT[a] != state_reg.ccer[a*CC_STRIDE+3]);
    end
  endgenerate
  assign bdtr_wr = do_wr & (state_reg.awaddr == BRK_DEADTIME_OFS) & state_reg.wstrb[1];

  sequence ch2_both_run;
    state_reg.master_out_en && !brk_ev && state_reg.ccer[10] && state_reg.ccer[8];
  endsequence
  sequence ch2_ref_rise;
    !state_reg.ref_prev[2] && REF_WAVE[2] && state_reg.dt != 8'h00;
  endsequence

  no_overlap_a: assert property (!(|(main_act & compl_act)))
    else $error("main and complementary active together");
  brk_clears_moe_a: assert property (brk_ev |=> !state_reg.master_out_en ##1 !state_reg.moe_s1)
    else $error("break did not clear master enable");
  brk_flag_a: assert property (brk_ev |=> state_reg.flag ##0 (BRK_IRQ == state_reg.irq_en)
                               && (BRK_DMA_REQ == state_reg.dma_en))
    else $error("break flag or interrupt missing");
  auto_oe_a: assert property (state_reg.auto_out_en && UPDATE_EVENT && !brk_ev |=> state_reg.master_out_en)
    else $error("auto enable did not restore master enable");
  brk_hold_a: assert property (brk_lvl && state_reg.flag |=> state_reg.flag && !state_reg.master_out_en)
    else $error("flag cleared or enable set during break");
  bke_delay_a: assert property (bdtr_wr && state_reg.lock == 2'b00
                                |=> ##1 state_reg.brk_enable == $past(state_reg.wdata[BRK_EN_BIT], 2))
    else $error("break enable not applied one cycle later");
  lock_once_a: assert property (state_reg.lock_done |=> $stable(state_reg.lock))
    else $error("lock field changed after first write");
  async_off_a: assert property (brk_async && state_reg.master_out_en |-> !(|main_act) && !(|compl_act))
    else $error("outputs active during asynchronous break");
  dt_delay_a: assert property (ch2_both_run ##0 ch2_ref_rise |=> !main_act[2])
    else $error("main output rose without dead-time");
  moe_sync_a: assert property (bdtr_wr && state_reg.wdata[MOE_BIT] && !brk_ev && !state_reg.master_out_en
                               ##1 (!brk_async)[*3] |-> state_reg.moe_s2)
    else $error("master enable readback not resynchronised");

endmodule // pob_top
`default_nettype wire

// *** pob_brk_src.sv ***
// Break source model: power stage alarm and clock monitor
`timescale 1ns/1ps
`default_nettype none
module pob_brk_src
(
  input  wire logic clk,
  input  wire logic trip,
  input  wire logic cf,
  input  wire logic slow,
  output logic      brk_in,
  output logic      cf_evt
);
  logic [2:0] dly_reg = 0;
  initial brk_in = 0;
  initial cf_evt = 0;
  always @(posedge clk)
  begin
    dly_reg <= {dly_reg[1:0], trip};
    brk_in  <= slow ? dly_reg[2] : trip;
    cf_evt  <= cf;
  end
endmodule // pob_brk_src
`default_nettype wire

// *** tb_pwm_output_steering_break.sv ***
// Testbench for the output steering and break block
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_pwm_output_steering_break;
  import pob_pkg::*;
  logic SYS_CLK = 0, RST = 1, UPDATE_EVENT = 0, trip = 0, cf = 0, slow = 0;
  logic [NUM_CH-1:0] REF_WAVE = 0;
  logic [ADDR_W-1:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0]       S_AXI_WDATA = 0, rng = 32'h0000_E6F6; // Seed 59126
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic BRK_IN, CLOCK_FAIL_MONITOR, BRK_IRQ, BRK_DMA_REQ;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [NUM_CH-1:0] MAIN_OUT, MAIN_OUT_OE, COMPL_OUT, COMPL_OUT_OE;
  logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0]       S_AXI_RDATA;
  logic [33:0]       q_rd[$];
  logic [35:0]       q_out[$];
  logic [35:0]       e;
  logic [1:0]        q_wr[$];
  logic [33:0]       rd_e;
  logic [1:0]        wr_e;
  int                error_cnt = 0, n_compared = 0, n;
  event              ev_out;
  always #5 SYS_CLK = ~SYS_CLK;
  pob_top dut (.SYS_CLK, .RST, .REF_WAVE, .UPDATE_EVENT, .BRK_IN, .CLOCK_FAIL_MONITOR,
    .MAIN_OUT, .MAIN_OUT_OE, .COMPL_OUT, .COMPL_OUT_OE, .BRK_IRQ, .BRK_DMA_REQ,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  pob_brk_src src (.clk(SYS_CLK), .trip, .cf, .slow, .brk_in(BRK_IN),
    .cf_evt(CLOCK_FAIL_MONITOR));
  ////////////////////////////////////////////////////////////////////////////////
  // Result checkers
  always @(posedge SYS_CLK)
  begin
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      rd_e = q_rd.pop_front();
      `CMP({S_AXI_RRESP, S_AXI_RDATA}, rd_e)
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      wr_e = q_wr.pop_front();
      `CMP(S_AXI_BRESP, wr_e)
    end
    if (!RST)
      `CMP(MAIN_OUT & COMPL_OUT, 4'h0)
  end
  always @(ev_out)
  begin
    e = q_out.pop_front();
    `CMP({BRK_IRQ, BRK_DMA_REQ, MAIN_OUT_OE, COMPL_OUT_OE, MAIN_OUT, COMPL_OUT} & e[35:18], e[17:0])
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 40)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    q_wr.push_back((a <= EVENT_GEN_OFS) ? RESP_OKAY : RESP_SLVERR);
    @(posedge SYS_CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID  <= 1;
    S_AXI_BREADY  <= 1;
    k = 0;
    do
    begin
      @(posedge SYS_CLK);
      k++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end
    while (!S_AXI_BVALID && k < 40);
    S_AXI_BREADY <= 0;
    tmo(k);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    int k;
    q_rd.push_back(x);
    @(posedge SYS_CLK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY  <= 1;
    k = 0;
    do
    begin
      @(posedge SYS_CLK);
      k++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end
    while (!S_AXI_RVALID && k < 40);
    S_AXI_RREADY <= 0;
    tmo(k);
  endtask
  task automatic chk(input logic [17:0] m, input logic [17:0] x);
    #1;
    q_out.push_back({m, x & m});
    -> ev_out;
  endtask
  task automatic upd();
    @(posedge SYS_CLK);
    UPDATE_EVENT <= 1;
    @(posedge SYS_CLK);
    UPDATE_EVENT <= 0;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 0;
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_0000});
    rd(8'h20, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h20, 32'h0000_0001);
    wr(CC_ENABLE_OFS, 32'h0000_0541);
    wr(CTRL2_OFS, 32'h0000_0019);
    wr(IRQ_DMA_EN_OFS, 32'h0000_0003);
    wr(BRK_DEADTIME_OFS, 32'h0000_F503);
    cyc(3);
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_F503});
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      @(posedge SYS_CLK);
      REF_WAVE <= {rng[3], i[0], rng[1:0]};
      cyc(10);
      chk(18'h3_FFFF, {6'h05, 4'h6, 1'b0, REF_WAVE[2], 1'b0, REF_WAVE[0],
        1'b0, ~REF_WAVE[2], REF_WAVE[1], 1'b0});
    end
    $display("test steering done");
    wr(BRK_DEADTIME_OFS, 32'h0000_8605);
    wr(CTRL2_OFS, 32'h0000_0000);
    cyc(3);
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_F503});
    rd(CTRL2_OFS, {RESP_OKAY, 32'h0000_0019});
    $display("test lock done");
    @(posedge SYS_CLK);
    REF_WAVE <= 4'hF;
    slow <= 1;
    cyc(10);
    trip <= 1;
    for (n = 0; n < 40 && !BRK_IN; n++) @(posedge SYS_CLK);
    tmo(n);
    chk(18'h0_00FF, 18'h0_0000);
    cyc(12);
    chk(18'h3_FFFF, {2'h3, 4'h7, 4'h7, 4'h5, 4'h2});
    wr(TIMER_STATUS_OFS, 32'h0000_0000);
    wr(BRK_DEADTIME_OFS, 32'h0000_F503);
    upd();
    cyc(3);
    rd(TIMER_STATUS_OFS, {RESP_OKAY, 32'h0000_0001});
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_7503});
    trip <= 0;
    slow <= 0;
    cyc(4);
    upd();
    cyc(4);
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_F503});
    wr(TIMER_STATUS_OFS, 32'h0000_0000);
    rd(TIMER_STATUS_OFS, {RESP_OKAY, 32'h0000_0000});
    $display("test break done");
    wr(EVENT_GEN_OFS, 32'h0000_0001);
    cyc(2);
    rd(TIMER_STATUS_OFS, {RESP_OKAY, 32'h0000_0001});
    rd(BRK_DEADTIME_OFS, {RESP_OKAY, 32'h0000_7503});
    rd(EVENT_GEN_OFS, {RESP_OKAY, 32'h0000_0000});
    wr(TIMER_STATUS_OFS, 32'h0000_0000);
    upd();
    cf <= 1;
    cyc(6);
    rd(TIMER_STATUS_OFS, {RESP_OKAY, 32'h0000_0001});
    cf <= 0;
    $display("test software and clock fail break done");
    cyc(4);
    stop_test();
  end
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule // tb_pwm_output_steering_break
`default_nettype wire
